// file: logic/rcjd_defs.svh
// constants of the rate converter and plug detect configuration registers
// assumes a 200 MHz system clock and an 8-bit internal register port
// Function
// RULE_01: control bit seven switches the rate converter on
// RULE_02: control bit six turns rate autodetection off
// RULE_03: ratio bit seven zero means main rate inferred
// RULE_04: ratio bit six picks primary or secondary port
// RULE_05: m field: 0 auto, 1-4, 6 literal
// RULE_06: n field: 0 auto, 1-4, 6 literal
// RULE_07: reserved bits read zero, host writes zero
// RULE_08: poll rate codes give 0.5, 1, 7.5 Hz
// RULE_09: probe pulse lasts 4 ms or 32 ms
// RULE_10: phone probe clock period 1, 2, 4 ms
// RULE_11: all four registers reset to zero
// RULE_12: mode bit one enables plug sensing
// RULE_13: mode bit three selects AC or DC coupling
// RULE_14: host avoids reserved field codes
`ifndef RCJD_DEFS_SVH
`define RCJD_DEFS_SVH

`define RCJD_CLK_KHZ          64'd200000
`define RCJD_ADDR_RC_CTRL     8'h17
`define RCJD_ADDR_RC_RATIO    8'h18
`define RCJD_ADDR_JD_TIMING   8'h19
`define RCJD_ADDR_JD_MODE     8'h1a
`define RCJD_RESET_VAL        8'h00
`define RCJD_MASK_RC_CTRL     8'hc0
`define RCJD_MASK_RC_RATIO    8'hff
`define RCJD_MASK_JD_TIMING   8'he6
`define RCJD_MASK_JD_MODE     8'h7e
// field positions
`define RCJD_BIT_RC_ON        7
`define RCJD_BIT_AUTODET_OFF  6
`define RCJD_BIT_MANUAL       7
`define RCJD_BIT_SRC_PICK     6
`define RCJD_M_HI             5
`define RCJD_M_LO             3
`define RCJD_N_HI             2
`define RCJD_N_LO             0
`define RCJD_POLL_HI          7
`define RCJD_POLL_LO          6
`define RCJD_BIT_PULSE_LEN    5
`define RCJD_CLKSEL_HI        2
`define RCJD_CLKSEL_LO        1
`define RCJD_BIT_COUPLING     3
`define RCJD_BIT_SENSE_ON     1
// field codes
`define RCJD_POLL_CODE_SLOW   2'h0
`define RCJD_POLL_CODE_MID    2'h1
`define RCJD_POLL_CODE_FAST   2'h2
`define RCJD_CLK_CODE_1       2'h0
`define RCJD_CLK_CODE_2       2'h1
`define RCJD_CLK_CODE_4       2'h2
`define RCJD_RATIO_RSV_A      3'h5
`define RCJD_RATIO_RSV_B      3'h7
// times: poll rates in millihertz, pulse and clock periods in ms
`define RCJD_POLL_SLOW_MHZ    64'd500
`define RCJD_POLL_MID_MHZ     64'd1000
`define RCJD_POLL_FAST_MHZ    64'd7500
`define RCJD_PULSE_SHORT_MS   64'd4
`define RCJD_PULSE_LONG_MS    64'd32
`define RCJD_CLK_1_MS         64'd1
`define RCJD_CLK_2_MS         64'd2
`define RCJD_CLK_4_MS         64'd4
`define RCJD_CYC_FROM_MHZ(f)  (32'((`RCJD_CLK_KHZ * 64'd1000000) / (f)))
`define RCJD_CYC_FROM_MS(t)   (32'(`RCJD_CLK_KHZ * (t)))

`endif

// file: logic/rcjd_pkg.sv
// types of the rate converter and plug detect configuration registers
// assumes rcjd_defs.svh for all numbers
`default_nettype none
package rcjd_pkg;
  typedef struct packed {
    logic [7:0]  rc_ctrl;
    logic [7:0]  rc_ratio;
    logic [7:0]  jd_timing;
    logic [7:0]  jd_mode;
    logic [7:0]  rdata;
    logic        rd_valid;
    logic        from_secondary;
    logic        main_auto;
    logic [2:0]  ratio_m;
    logic [2:0]  ratio_n;
    logic        ratio_bad;
    logic [31:0] poll_cnt;
    logic [31:0] pulse_cnt;
    logic        pulse;
    logic [31:0] clk_cnt;
    logic        tick;
  } rcjd_state_t;
endpackage : rcjd_pkg
`default_nettype wire

// file: logic/rcjd_cfg_regs.sv
// register slice for rate converter and plug detect setup, with poll timing
// assumes a same-clock register port driven by the control interface engine
`timescale 1ns/10ps
`include "rcjd_defs.svh"
`default_nettype none
module rcjd_cfg_regs
  import rcjd_pkg::*;
#(
  parameter logic [31:0] POLL_SLOW_CYC = `RCJD_CYC_FROM_MHZ(`RCJD_POLL_SLOW_MHZ),
  parameter logic [31:0] POLL_MID_CYC  = `RCJD_CYC_FROM_MHZ(`RCJD_POLL_MID_MHZ),
  parameter logic [31:0] POLL_FAST_CYC = `RCJD_CYC_FROM_MHZ(`RCJD_POLL_FAST_MHZ),
  parameter logic [31:0] PULSE_SHORT_CYC = `RCJD_CYC_FROM_MS(`RCJD_PULSE_SHORT_MS),
  parameter logic [31:0] PULSE_LONG_CYC  = `RCJD_CYC_FROM_MS(`RCJD_PULSE_LONG_MS),
  parameter logic [31:0] CLK_1_CYC = `RCJD_CYC_FROM_MS(`RCJD_CLK_1_MS),
  parameter logic [31:0] CLK_2_CYC = `RCJD_CYC_FROM_MS(`RCJD_CLK_2_MS),
  parameter logic [31:0] CLK_4_CYC = `RCJD_CYC_FROM_MS(`RCJD_CLK_4_MS)
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_reset,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  output logic            o_rd_valid,
  output logic            o_rate_converter_on,
  output logic            o_rate_autodetect_off,
  output logic            o_main_rate_auto,
  output logic            o_main_rate_from_secondary,
  output logic      [2:0] o_ratio_m,
  output logic      [2:0] o_ratio_n,
  output logic            o_ratio_code_bad,
  output logic            o_plug_sense_on,
  output logic            o_phone_coupling_dc,
  output logic            o_plug_probe_pulse,
  output logic            o_phone_probe_tick
);

  rcjd_state_t st;
  rcjd_state_t next_st;
  logic [31:0] poll_len;
  logic [31:0] pulse_len;
  logic [31:0] clk_len;
  logic        sense_en;

  // reserved codes map to a literal of zero and raise the bad flag
  function automatic logic [2:0] rcjd_ratio_val(input logic [2:0] code);
    if (code == `RCJD_RATIO_RSV_A || code == `RCJD_RATIO_RSV_B) begin
      return 3'h0;
    end
    return code;
  endfunction : rcjd_ratio_val

  always_comb begin
    unique case (st.jd_timing[`RCJD_POLL_HI:`RCJD_POLL_LO])  // see RULE_08
      `RCJD_POLL_CODE_MID:  poll_len = POLL_MID_CYC;
      `RCJD_POLL_CODE_FAST: poll_len = POLL_FAST_CYC;
      default:              poll_len = POLL_SLOW_CYC;  // reserved code 3 polls slowly
    endcase
    pulse_len = st.jd_timing[`RCJD_BIT_PULSE_LEN] ? PULSE_LONG_CYC : PULSE_SHORT_CYC;  // see RULE_09
    unique case (st.jd_timing[`RCJD_CLKSEL_HI:`RCJD_CLKSEL_LO])  // see RULE_10
      `RCJD_CLK_CODE_2: clk_len = CLK_2_CYC;
      `RCJD_CLK_CODE_4: clk_len = CLK_4_CYC;
      default:          clk_len = CLK_1_CYC;  // reserved code 3 falls back to 1 ms
    endcase
    sense_en = st.jd_mode[`RCJD_BIT_SENSE_ON];  // see RULE_12
  end

  always_comb begin
    next_st = st;
    next_st.rd_valid = 1'b0;
    // reserved bits are masked on write so they always read zero
    if (i_wr_en) begin
      unique case (i_addr)  // see RULE_07
        `RCJD_ADDR_RC_CTRL:   next_st.rc_ctrl   = i_wdata & `RCJD_MASK_RC_CTRL;
        `RCJD_ADDR_RC_RATIO:  next_st.rc_ratio  = i_wdata & `RCJD_MASK_RC_RATIO;
        `RCJD_ADDR_JD_TIMING: next_st.jd_timing = i_wdata & `RCJD_MASK_JD_TIMING;
        `RCJD_ADDR_JD_MODE:   next_st.jd_mode   = i_wdata & `RCJD_MASK_JD_MODE;
        default: ;
      endcase
    end
    if (i_rd_en) begin
      next_st.rd_valid = 1'b1;
      unique case (i_addr)
        `RCJD_ADDR_RC_CTRL:   next_st.rdata = st.rc_ctrl;
        `RCJD_ADDR_RC_RATIO:  next_st.rdata = st.rc_ratio;
        `RCJD_ADDR_JD_TIMING: next_st.rdata = st.jd_timing;
        `RCJD_ADDR_JD_MODE:   next_st.rdata = st.jd_mode;
        default:              next_st.rdata = `RCJD_RESET_VAL;
      endcase
    end
    // decoded controls lag the register by one cycle so outputs stay flopped
    next_st.main_auto      = ~st.rc_ratio[`RCJD_BIT_MANUAL];  // see RULE_03
    next_st.from_secondary = st.rc_ratio[`RCJD_BIT_MANUAL]
                           & st.rc_ratio[`RCJD_BIT_SRC_PICK];  // see RULE_04
    next_st.ratio_m   = rcjd_ratio_val(st.rc_ratio[`RCJD_M_HI:`RCJD_M_LO]);  // see RULE_05
    next_st.ratio_n   = rcjd_ratio_val(st.rc_ratio[`RCJD_N_HI:`RCJD_N_LO]);  // see RULE_06
    next_st.ratio_bad = (st.rc_ratio[`RCJD_M_HI:`RCJD_M_LO] != next_st.ratio_m)
                      | (st.rc_ratio[`RCJD_N_HI:`RCJD_N_LO] != next_st.ratio_n);
    // poll, probe pulse and probe clock all stop while sensing is off
    next_st.tick = 1'b0;
    if (!sense_en) begin
      next_st.poll_cnt  = 32'h0;
      next_st.pulse_cnt = 32'h0;
      next_st.pulse     = 1'b0;
      next_st.clk_cnt   = 32'h0;
    end else begin
      if (st.pulse) begin
        if (st.pulse_cnt >= pulse_len - 32'h1) begin
          next_st.pulse = 1'b0;
        end else begin
          next_st.pulse_cnt = st.pulse_cnt + 32'h1;
        end
      end
      if (st.poll_cnt >= poll_len - 32'h1) begin  // see RULE_08
        next_st.poll_cnt  = 32'h0;
        next_st.pulse     = 1'b1;
        next_st.pulse_cnt = 32'h0;
      end else begin
        next_st.poll_cnt = st.poll_cnt + 32'h1;
      end
      if (st.clk_cnt >= clk_len - 32'h1) begin  // see RULE_10
        next_st.clk_cnt = 32'h0;
        next_st.tick    = 1'b1;
      end else begin
        next_st.clk_cnt = st.clk_cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      st           <= '0;
      st.main_auto <= 1'b1;
      st.rc_ctrl   <= `RCJD_RESET_VAL;  // see RULE_11
      st.rc_ratio  <= `RCJD_RESET_VAL;
      st.jd_timing <= `RCJD_RESET_VAL;
      st.jd_mode   <= `RCJD_RESET_VAL;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata                    = st.rdata;
  assign o_rd_valid                 = st.rd_valid;
  assign o_rate_converter_on        = st.rc_ctrl[`RCJD_BIT_RC_ON];  // see RULE_01
  assign o_rate_autodetect_off      = st.rc_ctrl[`RCJD_BIT_AUTODET_OFF];  // see RULE_02
  assign o_main_rate_auto           = st.main_auto;
  assign o_main_rate_from_secondary = st.from_secondary;
  assign o_ratio_m                  = st.ratio_m;
  assign o_ratio_n                  = st.ratio_n;
  assign o_ratio_code_bad           = st.ratio_bad;
  assign o_plug_sense_on            = st.jd_mode[`RCJD_BIT_SENSE_ON];
  assign o_phone_coupling_dc        = st.jd_mode[`RCJD_BIT_COUPLING];  // see RULE_13
  assign o_plug_probe_pulse         = st.pulse;
  assign o_phone_probe_tick         = st.tick;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);

  property p_ctrl_write;
    i_wr_en && i_addr == `RCJD_ADDR_RC_CTRL |=>
      o_rate_converter_on == $past(i_wdata[`RCJD_BIT_RC_ON]) &&
      o_rate_autodetect_off == $past(i_wdata[`RCJD_BIT_AUTODET_OFF]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");  // see RULE_01

  property p_rsv_read;
    i_rd_en && !i_wr_en && i_addr == `RCJD_ADDR_JD_TIMING |=>
      o_rd_valid && (o_rdata & ~`RCJD_MASK_JD_TIMING) == 8'h00;
  endproperty
  a_rsv_read: assert property (p_rsv_read) else $error("reserved bits read nonzero");  // see RULE_07

  property p_manual_src;
    i_wr_en && i_addr == `RCJD_ADDR_RC_RATIO && i_wdata[`RCJD_BIT_SRC_PICK] |=>
      ##1 o_main_rate_from_secondary == $past(i_wdata[`RCJD_BIT_MANUAL], 2);
  endproperty
  a_manual_src: assert property (p_manual_src) else $error("main rate source wrong");  // see RULE_04

  property p_auto_main;
    i_wr_en && i_addr == `RCJD_ADDR_RC_RATIO && !i_wdata[`RCJD_BIT_MANUAL] |=>
      ##1 o_main_rate_auto && !o_main_rate_from_secondary;
  endproperty
  a_auto_main: assert property (p_auto_main) else $error("main rate not inferred");  // see RULE_03

  property p_m_reserved;
    i_wr_en && i_addr == `RCJD_ADDR_RC_RATIO &&
      i_wdata[`RCJD_M_HI:`RCJD_M_LO] == `RCJD_RATIO_RSV_A |=> ##1 o_ratio_code_bad;
  endproperty
  a_m_reserved: assert property (p_m_reserved) else $error("reserved m not flagged");  // see RULE_05

  property p_n_literal;
    i_wr_en && i_addr == `RCJD_ADDR_RC_RATIO && i_wdata[`RCJD_N_HI:`RCJD_N_LO] == 3'h6 |=>
      ##1 o_ratio_n == 3'h6;
  endproperty
  a_n_literal: assert property (p_n_literal) else $error("n literal wrong");  // see RULE_06

  property p_reset_zero;
    disable iff (1'b0) $past(i_reset) |-> st.rc_ctrl == 8'h00 && st.rc_ratio == 8'h00 &&
      st.jd_timing == 8'h00 && st.jd_mode == 8'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("register not zero after reset");  // see RULE_11

  property p_pulse_len;
    $fell(o_plug_probe_pulse) && $past(o_plug_sense_on) |->
      $past(st.pulse_cnt) == $past(pulse_len) - 32'h1;
  endproperty
  a_pulse_len: assert property (p_pulse_len) else $error("probe pulse length wrong");  // see RULE_09

  property p_tick_period;
    o_phone_probe_tick && $past(o_plug_sense_on) |->
      $past(st.clk_cnt) == $past(clk_len) - 32'h1;
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("probe clock period wrong");  // see RULE_10

  property p_poll_start;
    $rose(o_plug_probe_pulse) |-> $past(st.poll_cnt) == $past(poll_len) - 32'h1;
  endproperty
  a_poll_start: assert property (p_poll_start) else $error("poll interval wrong");  // see RULE_08

  property p_sense_off;
    !o_plug_sense_on |=> !o_plug_probe_pulse && !o_phone_probe_tick;
  endproperty
  a_sense_off: assert property (p_sense_off) else $error("probe active while off");  // see RULE_12

  property p_coupling;
    i_wr_en && i_addr == `RCJD_ADDR_JD_MODE |=>
      o_phone_coupling_dc == $past(i_wdata[`RCJD_BIT_COUPLING]);
  endproperty
  a_coupling: assert property (p_coupling) else $error("coupling not stored");  // see RULE_13

  c_pulse: cover property ($rose(o_plug_probe_pulse));
  c_tick: cover property (o_phone_probe_tick);
  c_bad_ratio: cover property ($rose(o_ratio_code_bad));
  c_read: cover property (o_rd_valid && o_rdata != 8'h00);

endmodule : rcjd_cfg_regs
`default_nettype wire

// file: testbench/rcjd_host_model.sv
// host model of the register port: single reads and writes
// assumes the slice samples requests at the rising clock edge
`timescale 1ns/10ps
`include "rcjd_defs.svh"
`default_nettype none
module rcjd_host_model (
  input  wire logic       i_clk_sys,
  output logic            o_wr_en,
  output logic            o_rd_en,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rd_valid
);
  initial begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end

  function automatic logic [7:0] keep(input logic [7:0] a);
    case (a)
      `RCJD_ADDR_RC_CTRL: keep = `RCJD_MASK_RC_CTRL;
      `RCJD_ADDR_JD_TIMING: keep = `RCJD_MASK_JD_TIMING;
      `RCJD_ADDR_JD_MODE: keep = `RCJD_MASK_JD_MODE;
      default: keep = 8'hff;
    endcase
  endfunction : keep

  // raw only when a scenario probes the slice's own masking; field codes
  // come from the caller, reserved ones only on purpose
  task automatic write(input logic [7:0] a, input logic [7:0] d, input bit raw);
    @(posedge i_clk_sys);
    o_wr_en <= 1'b1;
    o_addr <= a;
    o_wdata <= raw ? d : (d & keep(a));
    @(posedge i_clk_sys);
    o_wr_en <= 1'b0;
    // released lines carry the inverse, so stale values never pass as live
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask : write

  task automatic read(input logic [7:0] a, output logic [7:0] d, output bit ok);
    int n;
    ok = 1'b0;
    d = 8'h00;
    @(posedge i_clk_sys);
    o_rd_en <= 1'b1;
    o_addr <= a;
    @(posedge i_clk_sys);
    o_rd_en <= 1'b0;
    o_addr <= ~a;
    for (n = 0; n < 4 && !ok; n++) begin
      @(posedge i_clk_sys);
      ok = (i_rd_valid === 1'b1);
      d = i_rdata;
    end
  endtask : read
endmodule : rcjd_host_model
`default_nettype wire

// file: testbench/rate_conv_jack_detect_cfg_regs_tb_top.sv
// self-checking bench of the configuration register slice
// assumes the host model and the slice share one 200 MHz clock
`timescale 1ns/10ps
`include "rcjd_defs.svh"
`default_nettype none
module rate_conv_jack_detect_cfg_regs_tb_top;
  localparam int CLKS [3] = '{4, 8, 16};
  localparam int POLLS [3] = '{400, 200, 100};
  localparam int PULSES [2] = '{10, 40};
  localparam logic [7:0] MASKS [6] = '{8'h00, `RCJD_MASK_RC_CTRL,
    `RCJD_MASK_RC_RATIO, `RCJD_MASK_JD_TIMING, `RCJD_MASK_JD_MODE, 8'h00};
  logic       i_clk_sys, i_reset, wr_en, rd_en, rd_valid;
  logic [7:0] addr, wdata, rdata;
  logic       on, adoff, mauto, msec, bad, sense, dc, pulse, tick;
  logic [2:0] rm, rn;
  int         n_errors, n_tests, k, gap, hi;
  logic [7:0] v;

  // timing shrunk to bench scale; the same tables feed the expected periods
  rcjd_cfg_regs #(.POLL_SLOW_CYC(POLLS[0]), .POLL_MID_CYC(POLLS[1]),
    .POLL_FAST_CYC(POLLS[2]), .PULSE_SHORT_CYC(PULSES[0]), .PULSE_LONG_CYC(PULSES[1]),
    .CLK_1_CYC(CLKS[0]), .CLK_2_CYC(CLKS[1]), .CLK_4_CYC(CLKS[2])) u_rcjd_cfg_regs (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_wr_en(wr_en), .i_rd_en(rd_en),
    .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_rd_valid(rd_valid),
    .o_rate_converter_on(on), .o_rate_autodetect_off(adoff),
    .o_main_rate_auto(mauto), .o_main_rate_from_secondary(msec),
    .o_ratio_m(rm), .o_ratio_n(rn), .o_ratio_code_bad(bad),
    .o_plug_sense_on(sense), .o_phone_coupling_dc(dc),
    .o_plug_probe_pulse(pulse), .o_phone_probe_tick(tick));

  rcjd_host_model u_rcjd_host_model (.i_clk_sys(i_clk_sys), .o_wr_en(wr_en),
    .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata), .i_rdata(rdata),
    .i_rd_valid(rd_valid));

  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("errors=%0d checks=%0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bit ok;
    u_rcjd_host_model.read(a, d, ok);
    check(32'(ok), 32'h1);
    check({24'h0, d}, {24'h0, exp});
  endtask : rd_chk

  // decoded ratio outputs trail the register by one edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit raw);
    u_rcjd_host_model.write(a, d, raw);
    @(posedge i_clk_sys);
    #1;
  endtask : wr

  // period between two rises of the probe pulse or tick, and high time
  task automatic span(input bit sel, output int g, output int h);
    int r, n;
    logic prev, cur;
    g = 0;
    h = 0;
    r = 0;
    prev = 1'b1;
    for (n = 0; n < 2000 && r < 2; n++) begin
      @(posedge i_clk_sys);
      #1;
      cur = sel ? pulse : tick;
      if (cur && !prev) r++;
      if (r == 1) g++;
      if (r == 1 && cur) h++;
      prev = cur;
    end
  endtask : span

  function automatic logic [2:0] lit(input logic [2:0] c);
    return (c == 3'h5 || c == 3'h7) ? 3'h0 : c;
  endfunction : lit

  initial begin
    repeat (20000) @(posedge i_clk_sys);
    n_errors++;
    complete_run();
  end

  initial begin
    n_errors = 0;
    n_tests = 0;
    i_reset = 1'b1;
    repeat (16) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    for (k = 0; k < 4; k++) rd_chk(8'h17 + 8'(k), 8'h00);
    check(32'({mauto, on, sense, pulse, tick}), 32'h10);
    // all ones everywhere, unmapped neighbours included
    for (k = 0; k < 6; k++) begin
      wr(8'h16 + 8'(k), 8'hff, 1'b1);
      rd_chk(8'h16 + 8'(k), MASKS[k]);
    end
    for (k = 0; k < 4; k++) begin
      v = {k[1:0], 6'h00};
      wr(`RCJD_ADDR_RC_CTRL, v, 1'b0);
      check(32'({on, adoff}), 32'(v[7:6]));
    end
    for (k = 0; k < 8; k++) begin
      v = {k[1:0], k[2:0], 3'(7 - k)};
      wr(`RCJD_ADDR_RC_RATIO, v, 1'b0);
      check(32'({mauto, msec}), 32'({~v[7], v[7] & v[6]}));
      check(32'(rm), 32'(lit(v[5:3])));
      check(32'(rn), 32'(lit(v[2:0])));
      check(32'(bad), 32'((lit(v[5:3]) != v[5:3]) || (lit(v[2:0]) != v[2:0])));
    end
    for (k = 0; k < 2; k++) begin
      v = {4'h0, k[0], 3'h2};
      wr(`RCJD_ADDR_JD_MODE, v, 1'b0);
      check(32'({sense, dc}), 32'({v[1], v[3]}));
    end
    for (k = 0; k < 3; k++) begin
      wr(`RCJD_ADDR_JD_TIMING, {k[1:0], k[0], 2'h0, k[1:0], 1'b0}, 1'b0);
      span(1'b0, gap, hi);
      check(gap, CLKS[k]);
      span(1'b1, gap, hi);
      check(gap, POLLS[k]);
      check(hi, PULSES[k % 2]);
    end
    wr(`RCJD_ADDR_JD_MODE, 8'h00, 1'b0);
    @(posedge i_clk_sys);
    v = 8'h00;
    for (k = 0; k < 60; k++) begin
      @(posedge i_clk_sys);
      v = v | {6'h00, pulse, tick};
    end
    check(32'({sense, v}), 32'h0);
    complete_run();
  end
endmodule : rate_conv_jack_detect_cfg_regs_tb_top
`default_nettype wire
